// ---- dbpc_pkg.sv ----
// constants, types and reset values of the doppler bearing phase capture core
`default_nettype none

package dbpc_pkg;

    // ------------------------------------------------------------------
    // clock rates and divider figures
    // ------------------------------------------------------------------
    localparam int unsigned CORE_HZ     = 10_000_000;  // core_clk rate
    localparam int unsigned MASTER_HZ   = 1_000_000;   // scan master clock
    localparam int unsigned PRE_DIV     = CORE_HZ / MASTER_HZ;
    localparam logic [3:0]  PRE_MAX     = 4'(PRE_DIV - 1);
    localparam logic [2:0]  DIV5_MAX    = 3'h4;        // divide-by-five stage top
    localparam int unsigned SCAN_HZ     = 1250;        // antenna rotation rate
    localparam int unsigned FILT_DIV    = 8;           // filter clock divisor
    localparam int unsigned PUMP_HZ     = 16_000;      // nominal charge-pump rate

    // ------------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------------
    localparam int unsigned SCAN_W      = 7;           // scan counter stages
    localparam int unsigned CODE_W      = 5;           // bearing code width
    localparam int unsigned ANT_N       = 4;
    localparam int unsigned IND_N       = 32;
    localparam int unsigned ANT_LSB     = 3;           // counter bits four and five
    localparam int unsigned FDIV_W      = 6;
    localparam int unsigned FILT_BIT    = 2;           // master / 8
    localparam int unsigned PUMP_BIT    = 5;           // master / 64, about 16 kHz
    localparam logic [2:0]  QUARTER_END = 3'h7;        // last count of a quarter

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [SCAN_W-1:0] RST_SCAN  = 7'h00;
    localparam logic [CODE_W-1:0] RST_CODE  = 5'h00;
    localparam logic [ANT_N-1:0]  RST_SEL_N = 4'hE;    // antenna 0 chosen
    localparam logic [IND_N-1:0]  RST_IND_N = 32'hFFFFFFFE;

    // capture flip-flop states
    typedef enum logic [1:0] {
        CAP_ARMED = 2'b01,
        CAP_FIRED = 2'b10
    } dbpc_cap_e;

    // whole state of the core
    typedef struct packed {
        logic [3:0]        pre;
        logic [2:0]        div1;
        logic [2:0]        div2;
        logic [SCAN_W-1:0] scan;
        logic [FDIV_W-1:0] fdiv;
        dbpc_cap_e         cap;
        logic [CODE_W-1:0] code;
        logic [IND_N-1:0]  ind_n;
        logic [ANT_N-1:0]  sel_n;
        logic [1:0]        pll_sy;  // [0] first stage, [1] second stage
        logic [1:0]        hold_sy;
    } dbpc_state_s;

    // pin-facing outputs grouped
    typedef struct packed {
        logic [ANT_N-1:0] ant_sel_n;
        logic             filter_clk;
        logic             pump_clk;
    } dbpc_drive_s;

endpackage : dbpc_pkg

`default_nettype wire

// ---- dbpc_core.sv ----
// doppler bearing phase capture core: dividers, scan counter, capture, decode
//
// Behaviour
// R1: master clock divided by five twice gives 40 kHz scan counter clock.
// R2: seven-stage scan counter; low five bits always feed the bearing latch.
// R3: counter bits four and five decode one-of-four to antenna selects.
// R4: selects step clockwise, one full scan every 1/1250 second.
// R5: exactly one select low choosing its antenna, the other three high.
// R6: filter clock is master clock divided by eight.
// R7: inverted loop square wave high loads latch on next divider-stage clock edge.
// R8: latch strobe never coincides with a change of the counter bits.
// R9: captured five-bit code decoded by two one-of-sixteen halves into 32 lines.
// R10: exactly one of the 32 indicator lines active at a time.
// R11: hold keeps capture flip-flop reset so displayed bearing stays frozen.
// R12: about 16 kHz square wave from the divide-by-eight chain for charge pump.
// R13: capture clears after each load, rearms when loop input returns low.
`timescale 1ns/10ps
`default_nettype none

module dbpc_core
    import dbpc_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    input  wire logic                pll_square,
    input  wire logic                display_hold_switch,
    output var  dbpc_drive_s         drive,
    output logic [CODE_W-1:0]        counter_low_bits,
    output logic [CODE_W-1:0]        bearing_code,
    output logic [IND_N-1:0]         indicator_n
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // one-of-four, active low, clockwise antenna order
    function automatic logic [ANT_N-1:0] dec4_low(input logic [1:0] q);
        dec4_low = ~(4'h1 << q);
    endfunction

    // one-of-sixteen, active low, with a half enable
    function automatic logic [15:0] dec16_low(input logic [3:0] q, input logic en);
        dec16_low = en ? ~(16'h0001 << q) : 16'hFFFF;
    endfunction

    // ------------------------------------------------------------------
    // state and ticks
    // ------------------------------------------------------------------
    dbpc_state_s s_q;
    dbpc_state_s s_d;

    logic mtick;     // 1 MHz master tick
    logic tick200;   // first divide-by-five stage output edge
    logic tick40;    // second stage output edge, scan counter clock
    logic pll_d;     // inverted, synchronised loop square wave
    logic hold_s;
    logic load;

    assign mtick   = clk_en && (s_q.pre == PRE_MAX);
    assign tick200 = mtick && (s_q.div1 == DIV5_MAX);  // R1
    assign tick40  = tick200 && (s_q.div2 == DIV5_MAX);  // R1
    assign pll_d   = ~s_q.pll_sy[1];
    assign hold_s  = s_q.hold_sy[1];
    // strobe skips the edge on which the counter steps; the latch then takes
    // the next 200 kHz edge, a delay of 5 us against a 800 us scan
    assign load    = tick200 && !tick40 && pll_d && !hold_s
                     && (s_q.cap == CAP_ARMED);  // R7 R8 R11

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (clk_en) begin
            // pin synchronisers, first stage read only by the second; both
            // pins are asynchronous to core_clk, so nothing reads them raw
            s_d.pll_sy  = {s_q.pll_sy[0], pll_square};
            s_d.hold_sy = {s_q.hold_sy[0], display_hold_switch};

            // core clock prescaler to the master rate
            s_d.pre = (s_q.pre == PRE_MAX) ? 4'h0 : s_q.pre + 4'h1;

            if (mtick) begin
                // cascaded divide-by-five stages
                s_d.div1 = (s_q.div1 == DIV5_MAX) ? 3'h0 : s_q.div1 + 3'h1;  // R1
                if (tick200) begin
                    s_d.div2 = (s_q.div2 == DIV5_MAX) ? 3'h0 : s_q.div2 + 3'h1;  // R1
                end
                // filter and charge-pump divider chain
                s_d.fdiv = s_q.fdiv + 6'h01;  // R6 R12
            end

            // binary scan counter on the 40 kHz clock
            if (tick40) begin
                s_d.scan = s_q.scan + 7'h01;  // R2
            end

            // antenna selects follow counter bits four and five
            s_d.sel_n = dec4_low(s_d.scan[ANT_LSB +: 2]);  // R3 R4 R5

            // capture flip-flop: a load moves it to fired, so a second strobe
            // in the same tone period is refused; hold or the loop input going
            // low puts it back to armed, ready for the next tone edge
            case (s_q.cap)
                CAP_ARMED: begin
                    if (load) begin
                        s_d.code = s_q.scan[CODE_W-1:0];  // R7
                        s_d.cap  = CAP_FIRED;  // R13
                    end
                end
                CAP_FIRED: begin
                    if (!pll_d || hold_s) begin
                        s_d.cap = CAP_ARMED;  // R13 R11
                    end
                end
                default: begin
                    s_d.cap = CAP_ARMED;
                end
            endcase

            // indicator lines: bit four picks the half
            s_d.ind_n = {dec16_low(s_d.code[3:0], s_d.code[4]),
                         dec16_low(s_d.code[3:0], !s_d.code[4])};  // R9 R10
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q.pre     <= 4'h0;
            s_q.div1    <= 3'h0;
            s_q.div2    <= 3'h0;
            s_q.scan    <= RST_SCAN;
            s_q.fdiv    <= 6'h00;
            s_q.cap     <= CAP_ARMED;
            s_q.code    <= RST_CODE;
            s_q.ind_n   <= RST_IND_N;
            s_q.sel_n   <= RST_SEL_N;
            s_q.pll_sy  <= 2'h0;
            s_q.hold_sy <= 2'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign drive            = {s_q.sel_n,
                               s_q.fdiv[FILT_BIT],   // R6
                               s_q.fdiv[PUMP_BIT]};  // R12
    assign counter_low_bits = s_q.scan[CODE_W-1:0];  // R2
    assign bearing_code     = s_q.code;
    assign indicator_n      = s_q.ind_n;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_armed_load;
        load;
    endsequence

    sequence s_fired_high;
        (s_q.cap == CAP_FIRED) && pll_d && !hold_s && clk_en;
    endsequence

    // loop input ready and display not held
    sequence s_tone_ready;
        pll_d && !hold_s;
    endsequence

    // 200 kHz edge that is not also a counter step
    sequence s_divider_edge;
        tick200 && !tick40;
    endsequence

    // fired flip-flop about to rearm
    sequence s_fired_low;
        (s_q.cap == CAP_FIRED) && (!pll_d || hold_s) && clk_en;
    endsequence

    // scan counter moves only on the second stage edge
    a_scan_clock: assert property ($changed(s_q.scan) |-> $past(tick40))  // R1
        else $error("scan counter stepped off its 40 kHz clock");

    // scan counter steps by exactly one
    a_scan_step: assert property (tick40 |=> s_q.scan == $past(s_q.scan) + 7'h01)  // R2
        else $error("scan counter did not step by one");

    // selects always match counter bits four and five
    a_sel_match: assert property (drive.ant_sel_n == dec4_low(s_q.scan[ANT_LSB +: 2]))  // R3
        else $error("antenna select disagrees with counter");

    // selects change only at the end of a quarter
    a_sel_quarter: assert property ($changed(drive.ant_sel_n) |-> $past(s_q.scan[2:0]) == QUARTER_END)  // R4
        else $error("antenna select changed mid quarter");

    // exactly one antenna chosen
    a_ant_onehot: assert property ($onehot(~drive.ant_sel_n))  // R5
        else $error("not exactly one antenna select low");

    // filter clock edges only on master ticks
    a_filt_edge: assert property ($changed(drive.filter_clk) |-> $past(mtick) && $past(s_q.fdiv[1:0]) == 2'h3)  // R6
        else $error("filter clock edge off the divide by eight");

    // load takes the counter value seen at the strobe
    a_cap_load: assert property (s_armed_load |=> bearing_code == $past(counter_low_bits)
                                 && s_q.cap == CAP_FIRED)  // R7
        else $error("capture did not load counter bits");

    // strobe never on a counter step
    a_strobe_clear: assert property (load |-> !tick40 && $stable(s_q.scan))  // R8
        else $error("strobe coincides with counter change");

    // indicator decode of the captured code
    a_ind_decode: assert property (indicator_n == ~(32'h1 << bearing_code))  // R9
        else $error("indicator lines do not decode bearing code");

    // one indicator active
    a_ind_onehot: assert property ($onehot(~indicator_n))  // R10
        else $error("not exactly one indicator active");

    // hold freezes the bearing over two cycles
    a_hold_freeze: assert property (hold_s |=> $stable(bearing_code) ##1 !hold_s || $stable(bearing_code))  // R11
        else $error("bearing changed while held");

    // pump clock edges only when the lower five chain bits roll over
    a_pump_edge: assert property ($changed(drive.pump_clk) |-> $past(mtick) && $past(s_q.fdiv[4:0]) == 5'h1F)  // R12
        else $error("charge pump clock edge off its divider");

    // at most one load while the loop input stays high
    a_once_per: assert property (s_fired_high |=> $stable(bearing_code) && s_q.cap == CAP_FIRED)  // R13
        else $error("capture reloaded before rearming");

    // ------------------------------------------------------------------
    // divider, capture and decode invariants
    // ------------------------------------------------------------------

    // prescaler stays inside its count
    a_pre_range: assert property (s_q.pre <= PRE_MAX)  // R1
        else $error("prescaler beyond its top count");

    // both divide-by-five stages stay inside zero to four
    a_div_range: assert property (s_q.div1 <= DIV5_MAX && s_q.div2 <= DIV5_MAX)  // R1
        else $error("divide by five stage out of range");

    // second stage moves only on a first stage edge
    a_div2_quiet: assert property (!tick200 |=> $stable(s_q.div2))  // R1
        else $error("second divider stage moved off its clock");

    // filter chain moves only on master ticks
    a_fdiv_quiet: assert property (!mtick |=> $stable(s_q.fdiv))  // R6
        else $error("filter divider moved off the master tick");

    // selects walk clockwise, one position per change
    a_sel_walk: assert property ($changed(drive.ant_sel_n) |->  // R4
                                 drive.ant_sel_n == {$past(drive.ant_sel_n[2:0]), $past(drive.ant_sel_n[3])})
        else $error("antenna selects out of clockwise order");

    // a load only on a divider edge clear of a counter step
    a_load_edge: assert property (s_armed_load |-> s_divider_edge)  // R8
        else $error("load off a clean divider edge");

    // a load only with the loop input high and no hold
    a_load_ready: assert property (s_armed_load |-> s_tone_ready)  // R7
        else $error("load without a ready loop input");

    // the bearing moves only after a load
    a_code_steady: assert property (!load |=> $stable(bearing_code))  // R7
        else $error("bearing changed without a load");

    // hold blocks every load
    a_hold_noload: assert property (hold_s |-> !load)  // R11
        else $error("load while display held");

    // fired flip-flop rearms on hold or loop input low
    a_rearm_low: assert property (s_fired_low |=> s_q.cap == CAP_ARMED)  // R13
        else $error("capture did not rearm");

    // capture state is always one of its two codes
    a_cap_legal: assert property (s_q.cap == CAP_ARMED || s_q.cap == CAP_FIRED)  // R13
        else $error("capture state code illegal");

    // upper sixteen lines active only for codes with bit four set
    a_ind_half: assert property ((indicator_n[31:16] != 16'hFFFF) == bearing_code[4])  // R9
        else $error("indicator half disagrees with code");

    // indicator lines move only with the bearing code
    a_ind_follow: assert property ($changed(indicator_n) |-> $changed(bearing_code))  // R10
        else $error("indicator moved without a new code");

    // enable low freezes every flip-flop
    a_freeze_all: assert property (!clk_en |=> $stable(s_q))  // R2
        else $error("state moved with the clock enable low");

endmodule : dbpc_core

`default_nettype wire

// ---- dbpc_far_model.sv ----
// far side model: antenna switching unit and receiver tone
`timescale 1ns/10ps
`default_nettype none

module dbpc_far_model
    import dbpc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic [3:0]  ant_sel_n,
    input  wire logic        tone_on,
    input  wire logic [12:0] phase,
    output logic             pll_square = 1'b1,
    output logic             fault = 1'b0
);
    localparam int PER = CORE_HZ / SCAN_HZ;
    int         c = 0;
    int         d;
    logic [3:0] last_q = 4'hF;

    // tone phase locked to rotation start; a real tone cannot be seen before it
    always @(negedge core_clk) begin
        c = (ant_sel_n == 4'hE && last_q != 4'hE) ? 0 : (c + 1) % PER;
        last_q = ant_sel_n;
        d = (c + PER - int'(phase)) % PER;
        pll_square = !(tone_on && d < PER / 2);
        if ($countones(~ant_sel_n) != 1) fault = 1'b1;
    end
endmodule // dbpc_far_model

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the bearing capture core
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end

module tb_top;
    import dbpc_pkg::*;
    logic              core_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              hold = 1'b0;
    logic              clk_en = 1'b1;
    logic              tone_on = 1'b0;
    logic [12:0]       phase = 13'h0000;
    logic              pll_square;
    logic              fault;
    dbpc_drive_s       drive;
    logic [CODE_W-1:0] counter_low_bits;
    logic [CODE_W-1:0] bearing_code;
    logic [IND_N-1:0]  indicator_n;
    int                n_errors = 0;
    int                checked = 0;
    int                n;

    // 10 MHz core clock
    always #50 core_clk = ~core_clk;

    dbpc_core dbpc_core_i (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .pll_square(pll_square), .display_hold_switch(hold),
        .drive(drive), .counter_low_bits(counter_low_bits),
        .bearing_code(bearing_code), .indicator_n(indicator_n)
    );

    dbpc_far_model dbpc_far_model_i (
        .core_clk(core_clk), .ant_sel_n(drive.ant_sel_n), .tone_on(tone_on),
        .phase(phase), .pll_square(pll_square), .fault(fault)
    );

    // pick one output to watch for a change
    function automatic logic [31:0] probe(input int sel);
        case (sel)
            0: return 32'(drive.ant_sel_n);
            1: return 32'(counter_low_bits);
            2: return 32'(drive.filter_clk);
            default: return 32'(drive.pump_clk);
        endcase
    endfunction

    // cycles until the watched output next changes, bounded
    task automatic gap(input int sel, output int cnt);
        logic [31:0] v;
        v = probe(sel);
        cnt = 0;
        while (probe(sel) === v && cnt < 9000) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask

    task automatic t_reset();
        `CHK(drive.ant_sel_n, 4'hE, "reset select")
        `CHK(bearing_code, 5'h00, "reset code")
        `CHK(indicator_n, 32'hFFFFFFFE, "reset lines")
        $display("test reset done");
    endtask

    task automatic t_scan();
        logic [3:0] v;
        logic [4:0] w;
        gap(0, n);
        for (int i = 0; i < 4; i++) begin
            v = drive.ant_sel_n;
            gap(0, n);
            `CHK(n, 2000, "select dwell")
            `CHK(drive.ant_sel_n, {v[2:0], v[3]}, "select order")
        end
        gap(1, n);
        w = counter_low_bits;
        gap(1, n);
        `CHK(n, 250, "counter step")
        `CHK(counter_low_bits, w + 5'h01, "counter value")
        $display("test scan done");
    endtask

    task automatic t_clocks();
        gap(2, n);
        gap(2, n);
        `CHK(n, 40, "filter half period")
        gap(3, n);
        gap(3, n);
        `CHK(n, 320, "pump half period")
        $display("test clocks done");
    endtask

    // tone falls 100 cycles into count k, well clear of a counter step
    task automatic t_capture(input int k);
        phase = 13'(k * 250 + 100);
        tone_on = 1'b1;
        repeat (10000) @(negedge core_clk);
        `CHK(bearing_code, 5'(k), "captured code")
        `CHK(indicator_n, ~(32'h1 << k), "indicator line")
        $display("test capture %0d done", k);
    endtask

    task automatic t_hold();
        hold = 1'b1;
        phase = 13'(9 * 250 + 100);
        repeat (10000) @(negedge core_clk);
        `CHK(bearing_code, 5'h1F, "frozen code")
        hold = 1'b0;
        repeat (10000) @(negedge core_clk);
        `CHK(bearing_code, 5'h09, "code after release")
        $display("test hold done");
    endtask

    // enable low for more than two counter steps: nothing may move
    task automatic t_freeze();
        logic [4:0]  w;
        dbpc_drive_s v;
        w = counter_low_bits;
        v = drive;
        clk_en = 1'b0;
        repeat (600) @(negedge core_clk);
        `CHK(counter_low_bits, w, "frozen counter")
        `CHK(drive, v, "frozen drive")
        clk_en = 1'b1;
        $display("test freeze done");
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(negedge core_clk);
        t_reset();
        rst_n = 1'b1;
        t_scan();
        t_clocks();
        t_capture(0);
        t_capture(17);
        t_capture(31);
        t_hold();
        t_freeze();
        `CHK(fault, 1'b0, "select exclusivity")
        complete_run();
    end

    // watchdog, about 1.6 times the expected run
    initial begin
        #10_000_000;
        n_errors++;
        complete_run();
    end
endmodule // tb_top

`default_nettype wire
